// *** three_source_interrupt_ctrl_bench.sv ***
`timescale 1ns/10ps
module three_source_interrupt_ctrl_bench;
  import tsic_pkg::*;
  logic ref_clk = 0, arst_n = 0, p2 = 0, take, c, r, ri;
  logic [1:0] n = 0;
  logic [7:0] ra = 8'h0b, rd;
  logic [10:0] vec;
  tsic_src_s ev = '0;
  tsic_reg_s rq = '0;
  int mismatches = 0, check_count = 0;
  tsic_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .instruction_phase_two(p2), .events(ev),
    .reg_req(rq), .rd_addr(ra), .rd_data(rd), .call_exec(c), .subroutine_return_instr(r),
    .return_from_irq_instr(ri), .irq_take(take), .irq_vector(vec));
  tsic_core_model core_u (.ref_clk(ref_clk), .irq_take(take), .call_exec(c), .ret_plain(r),
    .ret_irq(ri));
  initial forever #2 ref_clk = ~ref_clk;
  // Phase-two strobe every fourth clock, like one instruction cycle.
  always @(posedge ref_clk) begin
    n <= n + 2'h1;
    p2 <= #1 (n == 2'h3);
  end
  ////////////////////////////////////////
  task automatic chk(string nm, logic [10:0] e, logic [10:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] d);
    @(posedge ref_clk);
    #1 rq = '{8'h0b, d, 1'b1};
    @(posedge ref_clk);
    #1 rq.wr = 1'b0;
  endtask
  // Bounded wait for an acknowledge; a missing one reads as 7ff.
  task automatic took(logic [10:0] e);
    int i;
    i = 0;
    do begin
      @(posedge ref_clk);
      #1 i++;
    end while (take !== 1'b1 && i < 12);
    chk("vector", e, take ? vec : 11'h7ff);
  endtask
  task automatic t_order;
    chk("reset", 11'h000, {3'h0, rd});
    wr(8'h0e);
    @(posedge ref_clk);
    #1 ev = 3'b111;
    @(posedge ref_clk);
    #1 ev = 3'b000;
    repeat (8) @(posedge ref_clk);
    chk("flags", 11'h07e, {3'h0, rd});
    ra = 8'h0c;
    #1 chk("unmapped", 11'h000, {3'h0, rd});
    ra = 8'h0b;
    wr(8'h7f);
    took(11'h004);
    chk("after", 11'h06e, {3'h0, rd});
    core_u.op(3'b001);
    took(11'h008);
    core_u.op(3'b010);
    repeat (10) @(posedge ref_clk);
    chk("ret", 11'h04e, {3'h0, rd});
    wr(8'h4f);
    took(11'h00c);
    $display("order test done");
  endtask
  task automatic t_full;
    repeat (3) core_u.op(3'b100);
    wr(8'h13);
    repeat (12) @(posedge ref_clk);
    chk("held", 11'h013, {3'h0, rd});
    core_u.op(3'b010);
    took(11'h004);
    wr(8'h00);
    #1 chk("clear", 11'h000, {3'h0, rd});
    $display("stack test done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 arst_n = 1'b1;
    t_order();
    t_full();
    end_sim();
  end
  // Whole run is about seventy clocks; this cuts a hang short.
  initial begin
    #40000 mismatches++;
    end_sim();
  end
endmodule

// *** tsic_checker.sv ***
`timescale 1ns/10ps
// Port-level checks; one clock domain, so defaults are declared once.
module tsic_checker
  import tsic_pkg::*;
#(parameter int PC_W = 11) (
  input wire logic ref_clk, // Clock.
  input wire logic arst_n, // Reset, active low.
  input wire logic instruction_phase_two, // Decision strobe.
  input wire tsic_reg_s reg_req, // Register write.
  input wire logic [7:0] rd_addr, // Read address.
  input wire logic [7:0] rd_data, // Read data.
  input wire logic return_from_irq_instr, // Interrupt return.
  input wire logic irq_take, // Acknowledge.
  input wire logic [PC_W-1:0] irq_vector // Vector.
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence masked_s;
    instruction_phase_two && rd_addr == 8'h0b && !rd_data[0];
  endsequence
  take_phase_a: assert property (irq_take |-> $past(instruction_phase_two)) else $error("take off phase");
  take_pulse_a: assert property (irq_take |=> !irq_take) else $error("take too long");
  vec_legal_a: assert property (irq_take |-> irq_vector inside {11'h004, 11'h008, 11'h00c}) else $error("bad vector");
  unmapped_zero_a: assert property (rd_addr != 8'h0b |-> rd_data == 8'h00) else $error("unmapped read");
  top_bit_a: assert property (!rd_data[7]) else $error("bit 7 set");
  master_clear_a: assert property (irq_take && rd_addr == 8'h0b && !$past(return_from_irq_instr) && !$past(reg_req.wr) |-> !rd_data[0]) else $error("master kept");
  masked_hold_a: assert property (masked_s |=> !irq_take) else $error("masked take");
  tb_first_a: assert property (irq_take && $past(rd_addr == 8'h0b && rd_data[1] && rd_data[4]) |-> irq_vector == 11'h004) else $error("priority");
  return_from_irq_instr_set_a: assert property (return_from_irq_instr |=> rd_addr != 8'h0b || rd_data[0]) else $error("return_from_irq_instr");
endmodule
////////////////////////////////////////
bind tsic_ctrl tsic_checker #(.PC_W(PC_W)) chk_u (.ref_clk(ref_clk), .arst_n(arst_n),
  .instruction_phase_two(instruction_phase_two), .reg_req(reg_req), .rd_addr(rd_addr),
  .rd_data(rd_data), .return_from_irq_instr(return_from_irq_instr), .irq_take(irq_take),
  .irq_vector(irq_vector));

// *** tsic_core_model.sv ***
`timescale 1ns/10ps
// Core sequencer stand-in: strobes calls and returns for one clock each.
module tsic_core_model (
  input wire logic ref_clk, // Clock.
  input wire logic irq_take, // Acknowledge from the controller.
  output logic call_exec, // Call strobe.
  output logic ret_plain, // Plain return strobe.
  output logic ret_irq // Interrupt return strobe.
);
  int depth = 0;
  initial {call_exec, ret_plain, ret_irq} = '0;
  // Only the return address is stacked; flags are software's job.
  always @(posedge ref_clk) depth <= depth + irq_take + call_exec - ret_plain - ret_irq;
  // Calls happen only when a test asks, never inside a routine by habit.
  task automatic op(input logic [2:0] k);
    @(posedge ref_clk);
    #1 {call_exec, ret_plain, ret_irq} = k;
    @(posedge ref_clk);
    #1 {call_exec, ret_plain, ret_irq} = '0;
  endtask
endmodule

// *** tsic_ctrl.sv ***
`timescale 1ns/10ps
`include "tsic_map.svh"
module tsic_ctrl
  import tsic_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int DEPTH = `TSIC_STACK_DEPTH
) (
  input wire logic ref_clk, // System clock, 250 MHz.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic instruction_phase_two, // One-cycle pulse at each phase-two edge.
  input wire tsic_src_s events, // One-cycle source events from same clock.
  input wire tsic_reg_s reg_req, // Data-memory write from the core.
  input wire logic [7:0] rd_addr, // Data-memory read address.
  output logic [7:0] rd_data, // Control register read value, zero elsewhere.
  input wire logic call_exec, // Core executes a call (pushes the stack).
  input wire logic subroutine_return_instr, // Core executes a plain return.
  input wire logic return_from_irq_instr, // Core executes an interrupt return.
  output logic irq_take, // Pulse: push the PC and branch to irq_vector.
  output logic [PC_W-1:0] irq_vector // Vector address, registered.
);
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [PC_W-1:0] vec_r, vec_nxt;
  logic take_r, take_nxt;
  logic stack_full;
  logic any_ret;
  logic [2:0] pend;
  logic [2:0] flags;

  assign any_ret = subroutine_return_instr | return_from_irq_instr;

  ////////////////////////////////////////////////////////////////////////
  // Stack occupancy; pushes come from calls and from our own acknowledge.
  tsic_stack_track #(
    .DEPTH(DEPTH)
  ) u_stack (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .push(call_exec | take_r),
    .pop(any_ret),
    .full(stack_full)
  );

  ////////////////////////////////////////////////////////////////////////
  // Pending view: flag and its enable; the master gate is applied below.
  assign flags = {ctrl_r[`TSIC_BIT_FLAG_TBB], ctrl_r[`TSIC_BIT_FLAG_TA],
                  ctrl_r[`TSIC_BIT_FLAG_TB]};
  assign pend[0] = flags[0] & ctrl_r[`TSIC_BIT_EN_TB];
  assign pend[1] = flags[1] & ctrl_r[`TSIC_BIT_EN_TA];
  assign pend[2] = flags[2] & ctrl_r[`TSIC_BIT_EN_TBB];

  // Next control word, arbitration and vector choice. Decisions are made
  // only on the phase-two pulse so that everything gathered since the
  // previous one is weighed together. The stack check waits for the
  // registered level, so a return's pop frees the slot only from the next cycle on.
  always_comb begin
    ctrl_nxt = ctrl_r;
    vec_nxt = vec_r;
    take_nxt = 1'b0;
    // Software write replaces the whole register; bit 7 stays zero.
    if (reg_req.wr && reg_req.addr == `TSIC_INTC_ADDR) begin
      ctrl_nxt = reg_req.wdata & `TSIC_CTRL_WMASK;
    end
    // Interrupt return reopens service; a plain return does not.
    if (return_from_irq_instr) begin
      ctrl_nxt[`TSIC_BIT_MASTER] = 1'b1;
    end
    // Service, in fixed priority, gated by master enable and stack room.
    if (instruction_phase_two && ctrl_r[`TSIC_BIT_MASTER] && !stack_full
        && !take_r) begin
      if (pend[0]) begin
        ctrl_nxt[`TSIC_BIT_FLAG_TB] = 1'b0;
        vec_nxt = `TSIC_VEC_TB;
        take_nxt = 1'b1;
      end else if (pend[1]) begin
        ctrl_nxt[`TSIC_BIT_FLAG_TA] = 1'b0;
        vec_nxt = `TSIC_VEC_TA;
        take_nxt = 1'b1;
      end else if (pend[2]) begin
        ctrl_nxt[`TSIC_BIT_FLAG_TBB] = 1'b0;
        vec_nxt = `TSIC_VEC_TBB;
        take_nxt = 1'b1;
      end
      if (take_nxt) begin
        ctrl_nxt[`TSIC_BIT_MASTER] = 1'b0;
      end
    end
    // Hardware events set flags last, so a set beats any clear.
    if (events.timebase) begin
      ctrl_nxt[`TSIC_BIT_FLAG_TB] = 1'b1;
    end
    if (events.timer_a) begin
      ctrl_nxt[`TSIC_BIT_FLAG_TA] = 1'b1;
    end
    if (events.timer_b) begin
      ctrl_nxt[`TSIC_BIT_FLAG_TBB] = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State registers; all service state is disabled at reset.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `TSIC_CTRL_RESET;
      vec_r <= PC_W'(`TSIC_VEC_NONE);
      take_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      vec_r <= vec_nxt;
      take_r <= take_nxt;
    end
  end

  // The core saves only the PC on this pulse; nothing else is stacked.
  assign irq_take = take_r;
  assign irq_vector = vec_r;
  // Read port shows the live register, unused bit 7 reads zero.
  assign rd_data = (rd_addr == `TSIC_INTC_ADDR) ? ctrl_r : 8'h00;
endmodule

// *** tsic_map.svh ***
`ifndef TSIC_MAP_SVH
`define TSIC_MAP_SVH
`define TSIC_INTC_ADDR 8'h0b
`define TSIC_BIT_MASTER 0
`define TSIC_BIT_EN_TB 1
`define TSIC_BIT_EN_TA 2
`define TSIC_BIT_EN_TBB 3
`define TSIC_BIT_FLAG_TB 4
`define TSIC_BIT_FLAG_TA 5
`define TSIC_BIT_FLAG_TBB 6
`define TSIC_CTRL_RESET 8'h00
`define TSIC_CTRL_WMASK 8'h7f
`define TSIC_VEC_TB 11'h004
`define TSIC_VEC_TA 11'h008
`define TSIC_VEC_TBB 11'h00c
`define TSIC_VEC_NONE 11'h000
`define TSIC_STACK_DEPTH 4
`endif

// *** tsic_pkg.sv ***
package tsic_pkg;
  typedef struct packed {
    logic timebase;
    logic timer_a;
    logic timer_b;
  } tsic_src_s;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } tsic_reg_s;
endpackage

// *** tsic_stack_track.sv ***
`timescale 1ns/10ps
`include "tsic_map.svh"
// Tracks return-stack occupancy so the controller knows when the stack is full.
module tsic_stack_track #(
  parameter int DEPTH = `TSIC_STACK_DEPTH
) (
  input wire logic ref_clk, // System clock.
  input wire logic arst_n, // Asynchronous reset, active low.
  input wire logic push, // One push this cycle (call or acknowledge).
  input wire logic pop, // One return this cycle.
  output logic full // Stack holds DEPTH entries.
);
  logic [$clog2(DEPTH+1)-1:0] level_r, level_nxt;

  // A call on a full stack wraps and loses the oldest entry, so level saturates.
  always_comb begin
    level_nxt = level_r;
    if (push && !pop && level_r != DEPTH[$clog2(DEPTH+1)-1:0]) begin
      level_nxt = level_r + 1'b1;
    end else if (pop && !push && level_r != '0) begin
      level_nxt = level_r - 1'b1;
    end
  end

  // Level register.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      level_r <= '0;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign full = (level_r == DEPTH[$clog2(DEPTH+1)-1:0]);
endmodule
